// file: logic/cmn_regs.svh
// cmn_regs.svh: field encodings and constants for the channel master clock
// and nco control block. assumes inclusion by cmn_pkg and the rtl modules.
`ifndef CMN_REGS_SVH
`define CMN_REGS_SVH

// ==========================================================================
// oscillator pin modes
`define CMN_OSC_MODE_OFF     2'h0
`define CMN_OSC_MODE_XTAL    2'h1
`define CMN_OSC_MODE_EXT     2'h2
// clock control after reset: only the ring oscillator runs
`define CMN_CLK_CTL_RESET    5'h02

// ==========================================================================
// nco block modes
`define CMN_NCO_MODE_PLAIN   4'h1
`define CMN_NCO_MODE_SPREAD  4'h2

// ==========================================================================
// loop input select: nco chosen when top two bits are 11
`define CMN_LOOP_SEL_NCO     2'h3
`define CMN_FREQ_W           40
`define CMN_FREQ_BYTES       5
`define CMN_NOMINAL_WORD     40'h80_0000_0000
// spread: center-spread triangle, step added or subtracted per tick
`define CMN_SPREAD_STEP      40'h00_0000_1000
`define CMN_SPREAD_LIMIT     40'h00_0A3D_70A3

`endif

// file: logic/cmn_pkg.sv
// cmn_pkg.sv: types for the channel master clock and nco control block.
// assumes cmn_regs.svh is on the include path.
package cmn_pkg;
`include "cmn_regs.svh"

    // ======================================================================
    // grouped configuration
    typedef struct packed {
        logic [1:0] osc_pin_mode;
        logic doubler_enable;
        logic nco_master_clock_select;
        logic ring_osc_disable;
    } cmn_master_cfg_t;

    typedef struct packed {
        logic crystal_drive_en;
        logic ext_osc_input_en;
        logic doubler_on;
        logic ring_osc_on;
        logic nco_clk_from_pin;
    } cmn_clk_ctl_t;

    typedef enum logic [2:0] {
        CMN_IDLE   = 3'b001,
        CMN_PLAIN  = 3'b010,
        CMN_SPREAD = 3'b100
    } cmn_state_t;
endpackage

// file: logic/cmn_word_stage.sv
// cmn_word_stage.sv: gathers byte writes of the 40-bit frequency word and
// commits all of it at once. assumes bytes come from same-clock logic.
`timescale 1ns/10ps
`include "cmn_regs.svh"
module cmn_word_stage
    import cmn_pkg::*;
#(
    parameter int BYTES = `CMN_FREQ_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic byte_wr,
    input wire logic [2:0] byte_idx,
    input wire logic [7:0] byte_data,
    output logic [BYTES*8-1:0] word,
    output logic word_valid
);
    logic [BYTES*8-1:0] shadow;
    logic [BYTES*8-1:0] next_shadow;
    logic [BYTES*8-1:0] next_word;
    logic next_word_valid;

    // ======================================================================
    // byte lanes
    genvar g;
    generate
        for (g = 0; g < BYTES; g++) begin : g_lane
            always_comb begin
                next_shadow[g*8 +: 8] = shadow[g*8 +: 8];
                if (byte_wr && byte_idx == 3'(g)) begin
                    next_shadow[g*8 +: 8] = byte_data;
                end
            end
        end
    endgenerate

    // final (highest) byte commits the whole word
    always_comb begin
        next_word = word;
        next_word_valid = 1'b0;
        if (byte_wr && byte_idx == 3'(BYTES - 1)) begin
            next_word = next_shadow;
            next_word_valid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shadow <= (BYTES*8)'(`CMN_NOMINAL_WORD);
            word <= (BYTES*8)'(`CMN_NOMINAL_WORD);
            word_valid <= 1'b0;
        end else begin
            shadow <= next_shadow;
            word <= next_word;
            word_valid <= next_word_valid;
        end
    end
endmodule

// file: logic/cmn_master_clock.sv
// cmn_master_clock.sv: per-channel master clock source control and nco
// frequency control. assumes software drives config ports on clk; pins
// and the gpio input arrive asynchronously and are synchronised here.
`timescale 1ns/10ps
`include "cmn_regs.svh"
// Function
// - osc mode 01 enables crystal driver
// - osc mode 10 takes external clock
// - doubler bit doubles master source
// - ring oscillator clocks registers after reset
// - select bit moves nco clock to pin in osc mode 10
// - ring disable bit powers ring down
// - each reference input gated by enable
// - unused third input serves as gpio
// - nco runs when enabled with mode 0001 or 0010, feeds loop when selected
// - mode 0001 plain nco
// - mode 0010 spread modulation around word
// - 40-bit unsigned frequency word
// - nominal word gives zero offset
module cmn_master_clock
    import cmn_pkg::*;
#(
    parameter int FREQ_W = `CMN_FREQ_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire cmn_master_cfg_t master_config_one,
    input wire logic [2:0] input_clock_enable_reg,
    input wire logic nco_block_enable,
    input wire logic [3:0] nco_mode,
    input wire logic [2:0] loop_input_select,
    input wire logic freq_byte_wr,
    input wire logic [2:0] freq_byte_idx,
    input wire logic [7:0] freq_byte_data,
    input wire logic nominal_word_rd,
    input wire logic general_io_three_out,
    input wire logic general_io_three_oe_req,
    input wire logic third_ref_pos_pin_in,
    output cmn_clk_ctl_t clk_ctl,
    output logic [2:0] ref_input_active,
    output logic general_io_three_in,
    output logic third_ref_pos_pin_out,
    output logic third_ref_pos_pin_oe,
    output logic nco_running,
    output logic nco_is_loop_ref,
    output logic [FREQ_W-1:0] nco_active_word,
    output logic [FREQ_W-1:0] nominal_frequency_word,
    output logic nominal_valid,
    output logic regs_on_ring_osc
);
    logic [FREQ_W-1:0] staged_word;
    logic [1:0] pin_sync;
    cmn_state_t state;
    cmn_state_t next_state;
    logic [FREQ_W-1:0] offset;
    logic [FREQ_W-1:0] next_offset;
    logic dir_down;
    logic next_dir_down;
    cmn_clk_ctl_t next_clk_ctl;
    logic [2:0] next_ref_active;
    logic next_pin_oe;
    logic next_pin_out;
    logic next_nco_running;
    logic next_nco_is_loop_ref;
    logic [FREQ_W-1:0] next_active_word;
    logic next_nominal_valid;
    logic next_regs_on_ring;
    logic next_gpio_in;
    // spread bounds sized to the word; the swing stays well inside
    // the combined deviation budget software must respect
    localparam logic [FREQ_W-1:0] SPREAD_STEP = FREQ_W'(`CMN_SPREAD_STEP);
    localparam logic [FREQ_W-1:0] SPREAD_LIMIT = FREQ_W'(`CMN_SPREAD_LIMIT);

    cmn_word_stage #(.BYTES(FREQ_W / 8)) u_stage (
        .clk(clk),
        .rst(rst),
        .byte_wr(freq_byte_wr),
        .byte_idx(freq_byte_idx),
        .byte_data(freq_byte_data),
        .word(staged_word),
        .word_valid()
    );

    // ======================================================================
    // master clock source control
    always_comb begin
        next_clk_ctl.crystal_drive_en =
            master_config_one.osc_pin_mode == `CMN_OSC_MODE_XTAL;
        next_clk_ctl.ext_osc_input_en =
            master_config_one.osc_pin_mode == `CMN_OSC_MODE_EXT;
        // doubler only meaningful with a live source behind it
        next_clk_ctl.doubler_on = master_config_one.doubler_enable &&
            (next_clk_ctl.crystal_drive_en ||
             next_clk_ctl.ext_osc_input_en);
        next_clk_ctl.ring_osc_on =
            !master_config_one.ring_osc_disable;
        // nco clock can come only from the pin in external mode
        next_clk_ctl.nco_clk_from_pin =
            master_config_one.nco_master_clock_select &&
            next_clk_ctl.ext_osc_input_en;
        // registers stay on ring until it is disabled or nco clock moves to the pin
        next_regs_on_ring = next_clk_ctl.ring_osc_on &&
            !next_clk_ctl.nco_clk_from_pin;
    end

    // ======================================================================
    // reference inputs and third pin as gpio
    always_comb begin
        next_ref_active = input_clock_enable_reg;
        next_pin_oe = !input_clock_enable_reg[2] &&
            general_io_three_oe_req;
        next_pin_out = next_pin_oe && general_io_three_out;
        next_gpio_in = pin_sync[1] && !input_clock_enable_reg[2];
    end

    // ======================================================================
    // nco mode state machine and spread sweep
    always_comb begin
        next_state = CMN_IDLE;
        if (nco_block_enable) begin
            unique case (nco_mode)
                `CMN_NCO_MODE_PLAIN: next_state = CMN_PLAIN;
                `CMN_NCO_MODE_SPREAD: next_state = CMN_SPREAD;
                default: next_state = CMN_IDLE;
            endcase
        end
        next_offset = '0;
        next_dir_down = 1'b0;
        if (state == CMN_SPREAD && next_state == CMN_SPREAD) begin
            // triangle center-spread, offset is signed two's complement
            if (dir_down) begin
                next_offset = offset - SPREAD_STEP;
                // turn at the low bound; steps never land on it exactly
                next_dir_down = !(next_offset[FREQ_W-1] &&
                    ((-next_offset) >= SPREAD_LIMIT));
            end else begin
                next_offset = offset + SPREAD_STEP;
                next_dir_down = (next_offset >= SPREAD_LIMIT) &&
                    !next_offset[FREQ_W-1];
            end
        end
        next_nco_running = next_state != CMN_IDLE;
        next_nco_is_loop_ref = next_nco_running &&
            loop_input_select[2:1] == `CMN_LOOP_SEL_NCO;
        // staged word arrives whole; nominal word means zero offset
        next_active_word = staged_word;
        if (next_state == CMN_SPREAD) begin
            next_active_word = staged_word + next_offset;
        end
        next_nominal_valid = nominal_word_rd;
    end

    // ======================================================================
    // source control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            // ring stays on through reset so registers keep a clock
            clk_ctl <= `CMN_CLK_CTL_RESET;
            regs_on_ring_osc <= 1'b1;
        end else begin
            clk_ctl <= next_clk_ctl;
            regs_on_ring_osc <= next_regs_on_ring;
        end
    end

    // ======================================================================
    // pin synchroniser: only the second stage is read downstream
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], third_ref_pos_pin_in};
        end
    end

    // ======================================================================
    // reference input and gpio registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_input_active <= 3'h0;
            third_ref_pos_pin_oe <= 1'b0;
            third_ref_pos_pin_out <= 1'b0;
            general_io_three_in <= 1'b0;
        end else begin
            ref_input_active <= next_ref_active;
            third_ref_pos_pin_oe <= next_pin_oe;
            third_ref_pos_pin_out <= next_pin_out;
            general_io_three_in <= next_gpio_in;
        end
    end

    // ======================================================================
    // nco registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= CMN_IDLE;
            offset <= '0;
            dir_down <= 1'b0;
            nco_running <= 1'b0;
            nco_is_loop_ref <= 1'b0;
            nco_active_word <= FREQ_W'(`CMN_NOMINAL_WORD);
            nominal_frequency_word <= FREQ_W'(`CMN_NOMINAL_WORD);
            nominal_valid <= 1'b0;
        end else begin
            state <= next_state;
            offset <= next_offset;
            dir_down <= next_dir_down;
            nco_running <= next_nco_running;
            nco_is_loop_ref <= next_nco_is_loop_ref;
            nco_active_word <= next_active_word;
            // held constant so software may read it at any time
            nominal_frequency_word <= FREQ_W'(`CMN_NOMINAL_WORD);
            nominal_valid <= next_nominal_valid;
        end
    end
endmodule

// file: verif/cmn_master_clock_asserts.sv
// cmn_master_clock_asserts.sv: port-level checks for cmn_master_clock.
// assumes cmn_pkg and cmn_regs.svh are compiled first; bound below.
`timescale 1ns/10ps
module cmn_master_clock_asserts
    import cmn_pkg::*;
#(
    parameter int FREQ_W = 40
) (
    input wire logic clk,
    input wire logic rst,
    input wire cmn_master_cfg_t master_config_one,
    input wire logic [2:0] input_clock_enable_reg,
    input wire logic nco_block_enable,
    input wire logic [3:0] nco_mode,
    input wire logic [2:0] loop_input_select,
    input wire logic freq_byte_wr,
    input wire logic [2:0] freq_byte_idx,
    input wire cmn_clk_ctl_t clk_ctl,
    input wire logic [2:0] ref_input_active,
    input wire logic third_ref_pos_pin_oe,
    input wire logic nco_running,
    input wire logic nco_is_loop_ref,
    input wire logic [FREQ_W-1:0] nco_active_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ======================================================================
    // source control
    a_xtal_drive: assert property (
        1'b1 |=> clk_ctl.crystal_drive_en ==
            ($past(master_config_one.osc_pin_mode) == 2'h1))
        else $error("crystal driver enable wrong");
    a_ext_input: assert property (
        1'b1 |=> clk_ctl.ext_osc_input_en ==
            ($past(master_config_one.osc_pin_mode) == 2'h2))
        else $error("external input enable wrong");
    a_doubler_gate: assert property (
        clk_ctl.doubler_on |-> $past(master_config_one.doubler_enable) &&
            $past(master_config_one.osc_pin_mode) inside {2'h1, 2'h2})
        else $error("doubler on without cause");
    a_pin_clock: assert property (
        master_config_one.nco_master_clock_select &&
            master_config_one.osc_pin_mode == 2'h2
            |=> clk_ctl.nco_clk_from_pin)
        else $error("nco clock not moved to pin");
    a_ring_power: assert property (
        master_config_one.ring_osc_disable |=> !clk_ctl.ring_osc_on)
        else $error("ring oscillator still on");

    // ======================================================================
    // inputs and nco
    a_ref_gate: assert property (
        1'b1 |=> ref_input_active == $past(input_clock_enable_reg))
        else $error("reference input gating wrong");
    a_gpio_release: assert property (
        input_clock_enable_reg[2] |=> !third_ref_pos_pin_oe)
        else $error("gpio driving while input used");
    a_nco_halt: assert property (
        !nco_block_enable |=> !nco_running)
        else $error("nco runs while disabled");
    a_loop_ref: assert property (
        nco_is_loop_ref |-> $past(loop_input_select[2:1]) == 2'h3)
        else $error("nco loop reference without select");
    // partial byte writes must never leak into the live word
    a_word_hold: assert property (
        (nco_mode == 4'h1 && !(freq_byte_wr && freq_byte_idx == 3'h4)) [*4]
            |=> $stable(nco_active_word))
        else $error("active word moved without commit");
endmodule

bind cmn_master_clock cmn_master_clock_asserts #(.FREQ_W(FREQ_W)) chk (
    .clk, .rst, .master_config_one, .input_clock_enable_reg,
    .nco_block_enable, .nco_mode, .loop_input_select, .freq_byte_wr,
    .freq_byte_idx, .clk_ctl, .ref_input_active, .third_ref_pos_pin_oe,
    .nco_running, .nco_is_loop_ref, .nco_active_word
);

// file: verif/test_channel_master_clock_and_nco.sv
// test_channel_master_clock_and_nco.sv: directed bench for cmn_master_clock.
// assumes cmn_pkg, cmn_regs.svh and the checker are compiled first.
`timescale 1ns/10ps
`include "cmn_regs.svh"
module test_channel_master_clock_and_nco;
    import cmn_pkg::*;
    logic clk = 0;
    logic rst = 1;
    cmn_master_cfg_t cfg = '0;
    cmn_clk_ctl_t ctl;
    logic [2:0] ice = '0, lsel = '0, bidx = '0, ract;
    logic [3:0] mode = '0;
    logic [7:0] bdat = '0;
    logic nen = 0, bwr = 0, nrd = 0, oreq = 0, gout = 0, pin = 0;
    logic gin, pout, poe, run, lref, nval, ring;
    logic [4:0] e;
    logic [39:0] aw, nw, w0, sw;
    int n_fail = 0;
    int num_checks = 0;

    always #10 clk = ~clk;

    cmn_master_clock uut (.clk(clk), .rst(rst), .master_config_one(cfg),
        .input_clock_enable_reg(ice), .nco_block_enable(nen),
        .nco_mode(mode), .loop_input_select(lsel), .freq_byte_wr(bwr),
        .freq_byte_idx(bidx), .freq_byte_data(bdat), .nominal_word_rd(nrd),
        .general_io_three_out(gout), .general_io_three_oe_req(oreq),
        .third_ref_pos_pin_in(pin), .clk_ctl(ctl), .ref_input_active(ract),
        .general_io_three_in(gin), .third_ref_pos_pin_out(pout),
        .third_ref_pos_pin_oe(poe), .nco_running(run), .nco_is_loop_ref(lref),
        .nco_active_word(aw), .nominal_frequency_word(nw),
        .nominal_valid(nval), .regs_on_ring_osc(ring));

    // ======================================================================
    // helpers
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk_bits(input string what, input logic [7:0] x, input logic [7:0] g);
        num_checks++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", what, x, g);
        end
    endtask
    task chk_word(input string what, input logic [39:0] x,
                  input logic [39:0] g);
        num_checks++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", what, x, g);
        end
    endtask
    task put_word(input logic [39:0] w, input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            bwr = 1;
            bidx = i[2:0];
            bdat = w[8*i +: 8];
            step(1);
        end
        bwr = 0;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ======================================================================
    // sequence
    initial begin
        step(12);
        chk_bits("ring_on", 8'h01, 8'(ctl.ring_osc_on));
        chk_bits("regs_ring", 8'h01, 8'(ring));
        chk_word("reset_word", `CMN_NOMINAL_WORD, aw);
        rst = 0;
        pin = 1;
        for (int m = 0; m < 4; m++) begin
            cfg = {m[1:0], 3'b110};
            step(1);
            e = {m == 1, m == 2, m == 1 || m == 2, 1'b1, m == 2};
            chk_bits("clk_ctl", 8'(e), 8'(ctl));
            chk_bits("regs_ring", 8'(m != 2), 8'(ring));
        end
        cfg.ring_osc_disable = 1;
        step(1);
        chk_bits("ring_off", 8'h00, 8'(ctl.ring_osc_on));
        chk_bits("regs_off", 8'h00, 8'(ring));
        // loop-only software keeps the ring on
        cfg.ring_osc_disable = 0;
        step(1);
        chk_bits("ring_back", 8'h01, 8'(ctl.ring_osc_on));
        // external oscillator stable: nco clock moves to the pin
        cfg = {2'h2, 3'b010};
        $display("test source control done");
        oreq = 1;
        gout = 1;
        for (int i = 0; i < 8; i++) begin
            ice = i[2:0];
            step(1);
            chk_bits("ref_active", 8'(i), 8'(ract));
            chk_bits("gpio_oe", 8'(!i[2]), 8'(poe));
            chk_bits("gpio_out", 8'(!i[2]), 8'(pout));
            chk_bits("gpio_in", 8'(!i[2]), 8'(gin));
        end
        $display("test inputs done");
        nen = 1;
        mode = 4'h1;
        lsel = 3'h6;
        step(1);
        chk_bits("running", 8'h01, 8'(run));
        chk_bits("loop_ref", 8'h01, 8'(lref));
        lsel = 3'h5;
        step(1);
        chk_bits("loop_other", 8'h00, 8'(lref));
        nen = 0;
        lsel = 3'h7;
        step(1);
        chk_bits("halted", 8'h00, 8'(run));
        chk_bits("loop_off", 8'h00, 8'(lref));
        nen = 1;
        mode = 4'h3;
        step(1);
        chk_bits("bad_mode", 8'h00, 8'(run));
        // spread sweep moves the live word up one step per tick from nominal
        mode = 4'h2;
        step(2);
        w0 = aw;
        step(1);
        sw = `CMN_NOMINAL_WORD + 2 * `CMN_SPREAD_STEP;
        chk_bits("spread_moves", 8'h01, 8'(aw !== w0));
        chk_word("spread_word", sw, aw);
        mode = 4'h1;
        step(4);
        chk_word("plain_word", `CMN_NOMINAL_WORD, aw);
        $display("test nco modes done");
        // stage four bytes only: live word must not change yet
        put_word(40'h80_0008_3127, 0, 3);
        step(3);
        chk_word("partial", `CMN_NOMINAL_WORD, aw);
        put_word(40'h80_0008_3127, 4, 4);
        chk_word("commit_wait", `CMN_NOMINAL_WORD, aw);
        step(1);
        chk_word("commit", 40'h80_0008_3127, aw);
        put_word(`CMN_NOMINAL_WORD, 0, 4);
        step(1);
        chk_word("back_nominal", `CMN_NOMINAL_WORD, aw);
        nrd = 1;
        step(1);
        nrd = 0;
        chk_bits("nominal_valid", 8'h01, 8'(nval));
        chk_word("nominal", `CMN_NOMINAL_WORD, nw);
        step(1);
        chk_bits("valid_drop", 8'h00, 8'(nval));
        $display("test frequency word done");
        put_word(40'h7F_FFF7_CED9, 0, 4);
        step(1);
        chk_word("minus_word", 40'h7F_FFF7_CED9, aw);
        rst = 1;
        step(2);
        chk_word("rerst_word", `CMN_NOMINAL_WORD, aw);
        chk_bits("rerst_run", 8'h00, 8'(run));
        chk_bits("rerst_ring", 8'h01, 8'(ring));
        rst = 0;
        step(1);
        chk_bits("rerun", 8'h01, 8'(run));
        chk_word("rerun_word", `CMN_NOMINAL_WORD, aw);
        $display("test mid-run reset done");
        tally_and_finish;
    end

    initial begin
        #1000000;
        n_fail++;
        tally_and_finish;
    end
endmodule
